// File: rplpc_bench.sv
// self-checking bench for the port lock/pass block
`timescale 1ns/1ps
`default_nettype none
module rplpc_bench;
   logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, reg_remote = 0, reg_ack, fwd_port;
   logic [6:0] reg_dev_addr = 7'h00, main_i2c_addr = 7'h3d;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
   logic [1:0] sync_det, bit_err, pclk_active, frame_end, frame_ok, rx_reset;
   logic [1:0] twelve = 2'b00, ten = 2'b00, link = 2'b00, pon = 2'b11, von = 2'b00;
   logic [15:0] vid_data0, vid_data1, fwd_data;
   logic vid_valid0, vid_valid1, vid_ready0, vid_ready1, fwd_valid, fwd_ready = 0;
   logic lock_pin, pass_pin, gpio_lock, ok, stall = 0, fwd_on = 0;
   integer err_total = 0, n_compared = 0, cyc = 0, rr0 = 0, s;
   logic [15:0] q[$];
   rplpc_top dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_remote(reg_remote), .reg_dev_addr(reg_dev_addr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .main_i2c_addr(main_i2c_addr), .sync_det(sync_det), .bit_err(bit_err),
      .pclk_active(pclk_active), .frame_end(frame_end), .frame_ok(frame_ok),
      .twelve_bit_high_freq_mode(twelve), .ten_bit_raw_mode(ten),
      .vid_data0(vid_data0), .vid_valid0(vid_valid0), .vid_data1(vid_data1),
      .vid_valid1(vid_valid1), .vid_ready0(vid_ready0), .vid_ready1(vid_ready1),
      .fwd_data(fwd_data), .fwd_port(fwd_port), .fwd_valid(fwd_valid),
      .fwd_ready(fwd_ready), .lock_pin(lock_pin), .pass_pin(pass_pin),
      .gpio_lock(gpio_lock), .rx_reset(rx_reset));
   rplpc_link_model p0 (.clk(clk), .link(link[0]), .pclk_on(pon[0]), .vid_on(von[0]),
      .vid_ready(vid_ready0), .sync_det(sync_det[0]), .bit_err(bit_err[0]),
      .pclk_active(pclk_active[0]), .frame_end(frame_end[0]), .frame_ok(frame_ok[0]),
      .vid_data(vid_data0), .vid_valid(vid_valid0));
   rplpc_link_model p1 (.clk(clk), .link(link[1]), .pclk_on(pon[1]), .vid_on(von[1]),
      .vid_ready(vid_ready1), .sync_det(sync_det[1]), .bit_err(bit_err[1]),
      .pclk_active(pclk_active[1]), .frame_end(frame_end[1]), .frame_ok(frame_ok[1]),
      .vid_data(vid_data1), .vid_valid(vid_valid1));
   initial begin
      forever #10 clk = ~clk;
   end
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task end_of_test;
      if (err_total == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one-cycle strobe, then up to three cycles for the ack
   task bus(input logic w, input logic r, input logic [6:0] dev, input logic [7:0] a,
      input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= !w;
      reg_remote <= r;
      reg_dev_addr <= dev;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      ok = 0;
      for (int i = 0; i < 3 && !ok; i++) begin
         #1 ok = (reg_ack === 1'b1);
         rd = reg_rdata;
         @(posedge clk);
      end
   endtask
   task rdc(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] m);
      bus(0, 0, dev, a, 8'h00);
      chk("read ack", 1, ok);
      chk("read data", e & m, rd & m);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_of_test;
      end
      fwd_ready <= !stall && $urandom_range(1, 0) == 1;
      if (rx_reset[0] === 1'b1) rr0++;
      // port 0 forwarding opens with its disable bit cleared; closed words are dropped
      if (reg_wr && reg_addr == 8'h20 && reg_dev_addr == main_i2c_addr) fwd_on <= !reg_wdata[4];
      if (vid_valid0 && vid_ready0 && fwd_on) q.push_back(vid_data0);
      if (fwd_valid === 1'b1 && fwd_ready) begin
         if (q.size() == 0) chk("fwd extra", 0, 1);
         else chk("fwd data", q.pop_front(), fwd_data);
         chk("fwd port", 0, fwd_port);
      end
   end
   initial begin
      s = $urandom(32'hea3f8708);
      repeat (3) @(posedge clk);
      rst <= 0;
      rdc(main_i2c_addr, 8'h0c, 8'h03, 8'hff);
      rdc(main_i2c_addr, 8'h20, 8'h30, 8'hff);
      rdc(main_i2c_addr, 8'h4c, 8'h01, 8'hff);
      bus(0, 0, 7'h00, 8'h0c, 8'h00);
      chk("stray ack", 0, ok);
      link[0] <= 1'b1;
      repeat (50) @(posedge clk);
      rdc(main_i2c_addr, 8'h4d, 8'h00, 8'h01);
      repeat (80) @(posedge clk);
      rdc(main_i2c_addr, 8'h4d, 8'h01, 8'h01);
      // a link-side write of zero must leave the port enable bits set
      bus(1, 1, main_i2c_addr, 8'h0c, 8'h00);
      rdc(main_i2c_addr, 8'h0c, 8'h03, 8'hff);
      for (int sel = 0; sel < 4; sel++) begin
         bus(1, 0, main_i2c_addr, 8'h0c, 8'h03 | 8'(sel << 2));
         repeat (3) @(posedge clk);
         chk("lock pin", 16'(sel % 2 == 0), lock_pin);
         rdc(main_i2c_addr, 8'h04, 8'(sel % 2 == 0) << 2, 8'h04);
      end
      bus(1, 0, main_i2c_addr, 8'h0c, 8'h0d);
      repeat (3) @(posedge clk);
      chk("lock and enabled", 1, lock_pin);
      bus(1, 0, main_i2c_addr, 8'h0c, 8'h03);
      chk("pass pin", 1, pass_pin);
      rdc(main_i2c_addr, 8'h4d, 8'h03, 8'h03);
      pon[0] <= 1'b0;
      twelve <= 2'b01;
      repeat (4) @(posedge clk);
      chk("hf lock pin", 0, lock_pin);
      rdc(main_i2c_addr, 8'h4d, 8'h01, 8'h01);
      twelve <= 2'b00;
      ten <= 2'b01;
      repeat (4) @(posedge clk);
      chk("raw lock pin", 1, lock_pin);
      von[0] <= 1'b1;
      repeat (30) @(posedge clk);
      chk("fwd closed", 0, fwd_valid);
      bus(1, 0, main_i2c_addr, 8'h20, 8'h20);
      repeat (100) @(posedge clk);
      stall <= 1'b1;
      repeat (12) @(posedge clk);
      chk("buffer full", 0, vid_ready0);
      stall <= 1'b0;
      repeat (100) @(posedge clk);
      von[0] <= 1'b0;
      repeat (30) @(posedge clk);
      chk("fwd drained", 0, 16'(q.size()));
      link[0] <= 1'b0;
      repeat (8) @(posedge clk);
      chk("rx reset pulses", 1, 16'(rr0));
      chk("lock lost", 0, lock_pin);
      link[0] <= 1'b1;
      repeat (130) @(posedge clk);
      rdc(main_i2c_addr, 8'h4d, 8'h01, 8'h01);
      bus(1, 0, main_i2c_addr, 8'h5c, 8'h42);
      rdc(7'h21, 8'h04, 8'h04, 8'h04);
      rdc(7'h21, 8'h4d, 8'h01, 8'h01);
      bus(1, 0, main_i2c_addr, 8'h5d, 8'h83);
      repeat (2) @(posedge clk);
      chk("gpio lock", 1, gpio_lock);
      end_of_test;
   end
endmodule
`default_nettype wire

// File: rplpc_defs.vh
// register map, field positions, reset values and timing counts of the port lock/pass block
`ifndef RPLPC_DEFS_VH
`define RPLPC_DEFS_VH
`define RPLPC_ADDR_DEVICE_STATUS 8'h04
`define RPLPC_ADDR_RECEIVER_PORT_CONTROL 8'h0c
`define RPLPC_ADDR_FWD_CTL 8'h20
`define RPLPC_ADDR_PAGE_SEL 8'h4c
`define RPLPC_ADDR_PORT_STS1 8'h4d
`define RPLPC_ADDR_PORT_I2C_ID 8'h5c
`define RPLPC_ADDR_PORT_CFG 8'h5d
// receiver_port_control fields
`define RPLPC_RPC_EN0 0
`define RPLPC_RPC_EN1 1
`define RPLPC_RPC_LOCK_SEL_LO 2
`define RPLPC_RPC_PASS_SEL_LO 4
`define RPLPC_RPC_RESET 8'h03
// forwarding_control: bits 5:4 disable per port (set = disabled)
`define RPLPC_FWD_DIS_LO 4
`define RPLPC_FWD_RESET 8'h30
// device_status fields
`define RPLPC_DSTS_LOCK 2
`define RPLPC_DSTS_PASS 3
// per-port config fields
`define RPLPC_CFG_ERR_CHK 0
`define RPLPC_CFG_LOCK_QUAL 1
`define RPLPC_CFG_PASS_BLOCK 2
`define RPLPC_CFG_RESET 8'h03
// receive_port_status_one fields
`define RPLPC_STS_LOCK 0
`define RPLPC_STS_PASS 1
// timing
`define RPLPC_CLK_MHZ 50
`define RPLPC_LOCK_STABLE_US 2
`define RPLPC_LOCK_STABLE_CYC (`RPLPC_LOCK_STABLE_US * `RPLPC_CLK_MHZ)
`define RPLPC_PASS_FRAMES 4'h3
`define RPLPC_CNT_W 8
`endif

// File: rplpc_link_model.sv
// remote serializer seen from one receive port: sync, frames and video words
`timescale 1ns/1ps
`default_nettype none
module rplpc_link_model (
   input wire logic clk, // clock
   input wire logic link, // link present
   input wire logic pclk_on, // pixel clock fed
   input wire logic vid_on, // send video
   input wire logic vid_ready, // receiver takes word
   output logic sync_det, // stream sync
   output logic bit_err, // never set here
   output logic pclk_active, // pixel clock seen
   output logic frame_end, // frame end pulse
   output logic frame_ok, // frame consistent
   output logic [15:0] vid_data, // video word
   output logic vid_valid // word offered
);
   logic [3:0] fc;
   initial begin
      {sync_det, bit_err, pclk_active, frame_end, frame_ok, vid_valid} = 6'h00;
      vid_data = 16'h0000;
      fc = 4'h0;
   end
   // frames are always good: sixteen cycles each while the link is up
   always @(posedge clk) begin
      sync_det <= link;
      pclk_active <= link & pclk_on;
      fc <= link ? fc + 4'h1 : 4'h0;
      frame_end <= link && fc == 4'hf;
      frame_ok <= link;
      if (!vid_valid || vid_ready) begin
         if (vid_on && link && $urandom_range(1, 0) == 1) begin
            vid_valid <= 1'b1;
            vid_data <= 16'($urandom);
         end else begin
            vid_valid <= 1'b0;
            vid_data <= ~vid_data;
         end
      end
   end
endmodule
`default_nettype wire

// File: rplpc_monitor.sv
// concurrent checks on the ports of the port lock/pass block
`timescale 1ns/1ps
`default_nettype none
module rplpc_monitor (
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [6:0] reg_dev_addr, // target address
   input wire logic [7:0] reg_addr, // offset
   input wire logic reg_ack, // access done
   input wire logic [6:0] main_i2c_addr, // main address
   input wire logic [1:0] sync_det, // stream sync
   input wire logic [1:0] bit_err, // bit errors
   input wire logic [1:0] pclk_active, // pixel clock
   input wire logic [1:0] frame_end, // frame end
   input wire logic [1:0] frame_ok, // frame good
   input wire logic [1:0] twelve_bit_high_freq_mode, // hf mode
   input wire logic fwd_valid, // forwarded word
   input wire logic lock_pin, // lock pin
   input wire logic pass_pin, // pass pin
   input wire logic [1:0] rx_reset // receiver reset
);
   logic [7:0] sc0, sc1;
   logic [1:0] g0, g1;
   logic fwd_seen;
   wire acc = reg_rd | reg_wr;
   // lower bounds only: the design may be stricter than these counters
   always @(posedge clk) begin
      if (rst) begin
         sc0 <= 8'h00;
         sc1 <= 8'h00;
         g0 <= 2'h0;
         g1 <= 2'h0;
         fwd_seen <= 1'b0;
      end else begin
         sc0 <= !sync_det[0] ? 8'h00 : (sc0 == 8'hff ? sc0 : sc0 + 8'h01);
         sc1 <= !sync_det[1] ? 8'h00 : (sc1 == 8'hff ? sc1 : sc1 + 8'h01);
         if (frame_end[0]) g0 <= !frame_ok[0] ? 2'h0 : (g0 == 2'h3 ? g0 : g0 + 2'h1);
         if (frame_end[1]) g1 <= !frame_ok[1] ? 2'h0 : (g1 == 2'h3 ? g1 : g1 + 2'h1);
         if (reg_wr && reg_addr == 8'h20) fwd_seen <= 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence main_acc;
      acc && reg_dev_addr == main_i2c_addr;
   endsequence
   sequence hf_dark;
      twelve_bit_high_freq_mode == 2'b11 && pclk_active == 2'b00;
   endsequence
   ack_follow_a: assert property (main_acc |=> reg_ack) else $error("access not acked");
   ack_cause_a: assert property (reg_ack |-> $past(acc)) else $error("ack without access");
   stray_dev_a: assert property (acc && reg_dev_addr == 7'h00 |=> !reg_ack)
      else $error("unmatched address acked");
   fwd_closed_a: assert property (!fwd_seen |-> !fwd_valid)
      else $error("forwarding before enable");
   lock_wait_a: assert property ($rose(lock_pin) |-> sc0 >= 8'd98 || sc1 >= 8'd98)
      else $error("lock before stable sync");
   pass_wait_a: assert property ($rose(pass_pin) |-> g0 == 2'h3 || g1 == 2'h3)
      else $error("pass before good frames");
   hf_dark_a: assert property (hf_dark [*3] |-> !lock_pin)
      else $error("lock pin without pixel clock");
   relock_reset_a: assert property (rx_reset[0] |-> $past(!sync_det[0]) ||
      $past(!sync_det[0], 2) || $past(!sync_det[0], 3) || $past(bit_err[0], 2))
      else $error("receiver reset without lock loss");
endmodule
bind rplpc_top rplpc_monitor mon (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_dev_addr(reg_dev_addr), .reg_addr(reg_addr), .reg_ack(reg_ack),
   .main_i2c_addr(main_i2c_addr), .sync_det(sync_det), .bit_err(bit_err),
   .pclk_active(pclk_active), .frame_end(frame_end), .frame_ok(frame_ok),
   .twelve_bit_high_freq_mode(twelve_bit_high_freq_mode), .fwd_valid(fwd_valid),
   .lock_pin(lock_pin), .pass_pin(pass_pin), .rx_reset(rx_reset));
`default_nettype wire

// File: rplpc_port.v
// one receive port: lock acquisition, pass qualification and frame truncation
`timescale 1ns/1ps
`default_nettype none
`include "rplpc_defs.vh"
module rplpc_port (
   input wire clk,               // system clock
   input wire rst,               // sync reset, high
   input wire port_en,           // receiver enabled
   input wire sync_det,          // stream synchronised this cycle
   input wire bit_err,           // link bit error pulse
   input wire err_chk,           // include bit errors in lock decision
   input wire frame_end,         // end-of-frame pulse
   input wire frame_ok,          // frame length and line count consistent
   output reg locked,            // per-port lock
   output reg pass,              // pass status
   output reg rx_reset,          // receiver reset pulse on lock loss
   output reg trunc              // truncate current frame
);
   localparam S_ACQ = 2'd0;
   localparam S_LOCK = 2'd1;
   localparam S_RST = 2'd2;
   reg [1:0] state;
   reg [`RPLPC_CNT_W-1:0] stable_cnt;
   reg [3:0] good_frames;
   reg frame_bad;
   wire err = err_chk & bit_err;
   // the count is an integer expression; keep only the counter's width on purpose
   wire [31:0] stable_full = `RPLPC_LOCK_STABLE_CYC - 1;
   wire [`RPLPC_CNT_W-1:0] stable_max = stable_full[`RPLPC_CNT_W-1:0];
   always @(posedge clk) begin
      if (rst || !port_en) begin
         state <= S_ACQ;
         stable_cnt <= {`RPLPC_CNT_W{1'b0}};
         locked <= 1'b0;
         rx_reset <= 1'b0;
      end else begin
         rx_reset <= 1'b0;
         case (state)
            S_ACQ: begin
               // lock only after sync holds error free for the stable time
               if (!sync_det || err) begin
                  stable_cnt <= {`RPLPC_CNT_W{1'b0}};
               end else if (stable_cnt == stable_max) begin
                  state <= S_LOCK;
                  locked <= 1'b1;
               end else begin
                  stable_cnt <= stable_cnt + 1'b1;
               end
            end
            S_LOCK: begin
               if (!sync_det || err) begin
                  state <= S_RST;
                  locked <= 1'b0;
                  rx_reset <= 1'b1;
               end
            end
            S_RST: begin
               stable_cnt <= {`RPLPC_CNT_W{1'b0}};
               state <= S_ACQ;
            end
            default: state <= S_ACQ;
         endcase
      end
   end
   // pass: count consecutive valid frames; any fault restarts the count
   always @(posedge clk) begin
      if (rst || !locked) begin
         good_frames <= 4'h0;
         pass <= 1'b0;
         frame_bad <= 1'b0;
         trunc <= 1'b0;
      end else begin
         if (err)
            frame_bad <= 1'b1;
         trunc <= err | (frame_bad & ~frame_end);
         if (frame_end) begin
            frame_bad <= 1'b0;
            if (frame_bad || err || !frame_ok) begin
               good_frames <= 4'h0;
               pass <= 1'b0;
            end else if (good_frames == `RPLPC_PASS_FRAMES - 4'h1) begin
               pass <= 1'b1;
            end else begin
               good_frames <= good_frames + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: rplpc_top.v
// receive port control, paging, forwarding gates and lock/pass status
// Functional notes
// - port control register can disable either or both receive inputs.
// - port disable bits written only by local I2C, never from the link.
// - page-select register picks which port's private registers are accessed.
// - each port has a programmable 7-bit I2C address reaching its registers directly.
// - per-port address also reaches the shared registers, but its writes to page select are ignored.
// - forwarding from all ports disabled after reset until software enables it.
// - lock/pass source select: 00 port0, 01 port1, 10 OR, 11 AND of enabled.
// - dedicated lock and pass pins, mirrored in the device status register.
// - each port locks only after synchronisation is stable.
// - optional bit-error checking in lock acquisition and loss.
// - per-port locked bit at bit 0 of receive port status register.
// - twelve-bit HF mode: lock pin needs active pixel clock; status bit does not.
// - ten-bit raw mode: input unused; lock pin follows port lock as with neither mode set.
// - per-port locked status can be routed to a GPIO output.
// - on lock loss the receiver resets and reruns lock acquisition.
// - frames with lock-loss errors are truncated; forwarding resumes after relock.
// - pass after a set number of valid frames, error free and consistent size.
// - option to truncate bad frames and block forwarding until pass.
// - port lock can qualify that port's forwarding enable.
`timescale 1ns/1ps
`default_nettype none
`include "rplpc_defs.vh"
module rplpc_top (
   input wire clk,                    // 50 MHz clock
   input wire rst,                    // sync reset, high
   input wire reg_wr,                 // register write strobe
   input wire reg_rd,                 // register read strobe
   input wire reg_remote,             // access came across the serial link
   input wire [6:0] reg_dev_addr,     // I2C target address of the access
   input wire [7:0] reg_addr,         // register offset
   input wire [7:0] reg_wdata,        // write data
   output reg [7:0] reg_rdata,        // read data
   output reg reg_ack,                // read/write done pulse
   input wire [6:0] main_i2c_addr,    // device's main I2C address
   input wire [1:0] sync_det,         // per-port stream synchronised
   input wire [1:0] bit_err,          // per-port link bit error pulse
   input wire [1:0] pclk_active,      // per-port serializer pixel clock active
   input wire [1:0] frame_end,        // per-port end-of-frame pulse
   input wire [1:0] frame_ok,         // per-port frame size consistent
   input wire [1:0] twelve_bit_high_freq_mode, // per-port mode: twelve-bit HF
   input wire [1:0] ten_bit_raw_mode, // per-port mode: ten-bit raw
   input wire [15:0] vid_data0,       // port 0 video word
   input wire vid_valid0,             // port 0 video valid
   input wire [15:0] vid_data1,       // port 1 video word
   input wire vid_valid1,             // port 1 video valid
   output reg vid_ready0,             // port 0 may deliver
   output reg vid_ready1,             // port 1 may deliver
   output reg [15:0] fwd_data,        // forwarded video word
   output reg fwd_port,               // source port of fwd_data
   output reg fwd_valid,              // forwarded word valid
   input wire fwd_ready,              // downstream accepts
   output reg lock_pin,               // lock output pin
   output reg pass_pin,               // pass output pin
   output reg gpio_lock,              // GPIO lock monitor output
   output reg [1:0] rx_reset          // per-port receiver reset pulse
);
   reg [7:0] receiver_port_control;
   reg [7:0] fwd_ctl;
   reg [1:0] page_sel;
   reg [6:0] port_id0;
   reg [6:0] port_id1;
   reg [7:0] port_cfg0;
   reg [7:0] port_cfg1;
   reg gpio_sel_en;
   reg gpio_sel_port;
   wire [1:0] locked;
   wire [1:0] pass;
   wire [1:0] trunc;
   wire [1:0] port_rst;
   wire [1:0] port_en = receiver_port_control[1:0];
   wire [1:0] err_chk = {port_cfg1[`RPLPC_CFG_ERR_CHK], port_cfg0[`RPLPC_CFG_ERR_CHK]};
   // direct port access through its own address, else paging
   wire hit0 = (port_id0 != 7'h00) && (reg_dev_addr == port_id0);
   wire hit1 = (port_id1 != 7'h00) && (reg_dev_addr == port_id1);
   wire hit_main = reg_dev_addr == main_i2c_addr;
   wire addr_ok = hit_main | hit0 | hit1;
   wire [1:0] sel = hit0 ? 2'b01 : (hit1 ? 2'b10 : page_sel);
   wire rd_port = sel[1] & ~sel[0];

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_port
         rplpc_port u_port (
            .clk(clk),
            .rst(rst),
            .port_en(port_en[g]),
            .sync_det(sync_det[g]),
            .bit_err(bit_err[g]),
            .err_chk(err_chk[g]),
            .frame_end(frame_end[g]),
            .frame_ok(frame_ok[g]),
            .locked(locked[g]),
            .pass(pass[g]),
            .rx_reset(port_rst[g]),
            .trunc(trunc[g])
         );
      end
   endgenerate

   // pin-level lock: HF mode also needs an active pixel clock; ten_bit_raw_mode is not used
   wire [1:0] pin_lock;
   assign pin_lock = locked & ~(twelve_bit_high_freq_mode & ~pclk_active);

   function sel_src;
      input [1:0] s;
      input [1:0] v;
      input [1:0] en;
      begin
         case (s)
            2'b00: sel_src = v[0];
            2'b01: sel_src = v[1];
            2'b10: sel_src = |(v & en);
            2'b11: sel_src = (en != 2'b00) && ((v & en) == en);
            default: sel_src = 1'b0;
         endcase
      end
   endfunction
   wire next_lock = sel_src(receiver_port_control[3:2], pin_lock, port_en);
   wire next_pass = sel_src(receiver_port_control[5:4], pass, port_en);

   // forwarding gate: enable, optional lock qualify, optional pass block
   wire [1:0] fwd_en = ~fwd_ctl[5:4];
   wire [1:0] lock_q = {port_cfg1[`RPLPC_CFG_LOCK_QUAL], port_cfg0[`RPLPC_CFG_LOCK_QUAL]};
   wire [1:0] pass_b = {port_cfg1[`RPLPC_CFG_PASS_BLOCK], port_cfg0[`RPLPC_CFG_PASS_BLOCK]};
   wire [1:0] gate = fwd_en & port_en & (~lock_q | locked) & (~pass_b | pass);

   // two-entry buffer; truncated words are dropped, not stalled
   reg [15:0] buf_d0;
   reg [15:0] buf_d1;
   reg buf_p0;
   reg buf_p1;
   reg [1:0] cnt;
   reg rr;
   wire pick1 = vid_valid1 & gate[1] & (~(vid_valid0 & gate[0]) | rr);
   wire take0 = vid_ready0 & vid_valid0 & gate[0] & ~pick1;
   wire take1 = vid_ready1 & pick1;
   wire keep0 = take0 & ~trunc[0];
   wire keep1 = take1 & ~trunc[1];
   wire push = keep0 | keep1;
   wire pop = fwd_valid & fwd_ready;
   wire [1:0] next_cnt = cnt + {1'b0, push} - {1'b0, pop};
   always @(posedge clk) begin
      if (rst) begin
         cnt <= 2'd0;
         rr <= 1'b0;
         buf_d0 <= 16'h0000;
         buf_d1 <= 16'h0000;
         buf_p0 <= 1'b0;
         buf_p1 <= 1'b0;
         fwd_valid <= 1'b0;
         fwd_data <= 16'h0000;
         fwd_port <= 1'b0;
         vid_ready0 <= 1'b0;
         vid_ready1 <= 1'b0;
      end else begin
         if (take0 | take1)
            rr <= ~rr;
         cnt <= next_cnt;
         // head in slot 0; slot 1 holds a second word while stalled
         if (pop) begin
            buf_d0 <= (cnt == 2'd2) ? buf_d1 : (keep1 ? vid_data1 : vid_data0);
            buf_p0 <= (cnt == 2'd2) ? buf_p1 : keep1;
            if (cnt == 2'd2 && push) begin
               buf_d1 <= keep1 ? vid_data1 : vid_data0;
               buf_p1 <= keep1;
            end
         end else if (push) begin
            if (cnt == 2'd0) begin
               buf_d0 <= keep1 ? vid_data1 : vid_data0;
               buf_p0 <= keep1;
            end else begin
               buf_d1 <= keep1 ? vid_data1 : vid_data0;
               buf_p1 <= keep1;
            end
         end
         fwd_valid <= next_cnt != 2'd0;
         fwd_data <= (pop || cnt == 2'd0) ?
            ((pop && cnt == 2'd2) ? buf_d1 : (keep1 ? vid_data1 : vid_data0)) : buf_d0;
         fwd_port <= (pop || cnt == 2'd0) ?
            ((pop && cnt == 2'd2) ? buf_p1 : keep1) : buf_p0;
         // ready only while a free slot is guaranteed next cycle
         vid_ready0 <= next_cnt == 2'd0 || (next_cnt == 2'd1 && !(fwd_valid && !fwd_ready));
         vid_ready1 <= next_cnt == 2'd0 || (next_cnt == 2'd1 && !(fwd_valid && !fwd_ready));
      end
   end

   // register writes
   always @(posedge clk) begin
      if (rst) begin
         receiver_port_control <= `RPLPC_RPC_RESET;
         fwd_ctl <= `RPLPC_FWD_RESET;
         page_sel <= 2'b01;
         port_id0 <= 7'h00;
         port_id1 <= 7'h00;
         port_cfg0 <= `RPLPC_CFG_RESET;
         port_cfg1 <= `RPLPC_CFG_RESET;
         gpio_sel_en <= 1'b0;
         gpio_sel_port <= 1'b0;
      end else if (reg_wr && addr_ok) begin
         case (reg_addr)
            `RPLPC_ADDR_RECEIVER_PORT_CONTROL: begin
               receiver_port_control[7:2] <= reg_wdata[7:2];
               if (!reg_remote)
                  receiver_port_control[1:0] <= reg_wdata[1:0];
            end
            `RPLPC_ADDR_FWD_CTL: fwd_ctl <= reg_wdata;
            `RPLPC_ADDR_PAGE_SEL: begin
               if (!hit0 && !hit1)
                  page_sel <= reg_wdata[1:0];
            end
            `RPLPC_ADDR_PORT_I2C_ID: begin
               if (sel[0])
                  port_id0 <= reg_wdata[7:1];
               if (sel[1])
                  port_id1 <= reg_wdata[7:1];
            end
            `RPLPC_ADDR_PORT_CFG: begin
               if (sel[0])
                  port_cfg0 <= reg_wdata;
               if (sel[1])
                  port_cfg1 <= reg_wdata;
               gpio_sel_en <= reg_wdata[7];
               gpio_sel_port <= reg_wdata[6];
            end
            default: ;
         endcase
      end
   end

   // register reads, status pins
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         reg_ack <= 1'b0;
         lock_pin <= 1'b0;
         pass_pin <= 1'b0;
         gpio_lock <= 1'b0;
         rx_reset <= 2'b00;
      end else begin
         reg_ack <= (reg_wr | reg_rd) & addr_ok;
         lock_pin <= next_lock;
         pass_pin <= next_pass;
         gpio_lock <= gpio_sel_en & locked[gpio_sel_port];
         rx_reset <= port_rst;
         if (reg_rd && addr_ok) begin
            case (reg_addr)
               `RPLPC_ADDR_DEVICE_STATUS:
                  reg_rdata <= {4'h0, pass_pin, lock_pin, 2'b00};
               `RPLPC_ADDR_RECEIVER_PORT_CONTROL: reg_rdata <= receiver_port_control;
               `RPLPC_ADDR_FWD_CTL: reg_rdata <= fwd_ctl;
               `RPLPC_ADDR_PAGE_SEL: reg_rdata <= {4'h0, rd_port, 1'b0, sel};
               `RPLPC_ADDR_PORT_STS1:
                  reg_rdata <= {6'h00, pass[rd_port], locked[rd_port]};
               `RPLPC_ADDR_PORT_I2C_ID:
                  reg_rdata <= {rd_port ? port_id1 : port_id0, 1'b0};
               `RPLPC_ADDR_PORT_CFG:
                  reg_rdata <= rd_port ? port_cfg1 : port_cfg0;
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule
`default_nettype wire
